// ===== bench/rtc_top_test.sv
// testbench for the real-time clock with backup store
// assumes rtc_pkg and rtc_top compiled first; slow clocks are bench pins
`timescale 1ns/10ps
module rtc_top_test
  import rtc_pkg::*;
;
  logic        clk, rst_n, bkp_rst_n, lse, lsi, high_speed_external_clock, stop, stby;
  logic        pre_ld, cnt_ld, alm_ld, cal_en, we;
  logic [19:0] pre_val;
  logic [31:0] cnt_val, alm_val, c;
  logic [5:0]  addr;
  logic [15:0] wdata;
  clk_src_e    src;
  rtc_flags_s  clr, mask;
  int          err_count, checks, ev_n, sb_n, cal_t;
  logic [31:0] COUNT_OUT;
  rtc_flags_s  FLAGS_OUT;
  logic        ALARM_IRQ_OUT, TICK_IRQ_OUT, CAL_OUT, EXT_OUT, SB_OUT, cal_p;
  logic [15:0] BKP_RDATA_OUT;
  rtc_top rtc_top_i (.CLK_IN(clk), .RESET_N_IN(rst_n), .BKP_RESET_N_IN(bkp_rst_n),
    .LSE_CLK_IN(lse), .LSI_CLK_IN(lsi), .HIGH_SPEED_EXTERNAL_CLOCK_IN(high_speed_external_clock),
    .CLK_SRC_IN(src), .STOP_IN(stop), .STANDBY_IN(stby), .PRE_RELOAD_IN(pre_val),
    .PRE_LOAD_IN(pre_ld), .CNT_WDATA_IN(cnt_val), .CNT_LOAD_IN(cnt_ld),
    .ALARM_WDATA_IN(alm_val), .ALARM_LOAD_IN(alm_ld), .FLAG_CLR_IN(clr),
    .IRQ_MASK_IN(mask), .CAL_EN_IN(cal_en), .BKP_WE_IN(we), .BKP_ADDR_IN(addr),
    .BKP_WDATA_IN(wdata), .COUNT_OUT(COUNT_OUT), .FLAGS_OUT(FLAGS_OUT),
    .ALARM_IRQ_OUT(ALARM_IRQ_OUT), .TICK_IRQ_OUT(TICK_IRQ_OUT), .CAL_OUT(CAL_OUT),
    .EXTERNAL_EVENT_LINE_OUT(EXT_OUT), .STANDBY_EXIT_OUT(SB_OUT),
    .BKP_RDATA_OUT(BKP_RDATA_OUT));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // one-cycle pulses counted away from the active edge to avoid races
  always @(negedge clk)
  begin
    ev_n += int'(EXT_OUT);
    sb_n += int'(SB_OUT);
    cal_t += int'(CAL_OUT !== cal_p);
    cal_p = CAL_OUT;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // only the selected pin toggles, so a wrong selection shows as no count
  task pulse(input int n);
    repeat (n)
    begin
      {lse, lsi, high_speed_external_clock} = {src == SRC_LSE, src == SRC_LSI, src == SRC_HSE};
      step(4);
      {lse, lsi, high_speed_external_clock} = 3'h0;
      step(4);
    end
    step(8);
  endtask
  task set_pre(input logic [19:0] v);
    pre_val = v; pre_ld = 1'b1; step(1); pre_ld = 1'b0; step(1);
  endtask
  task t_sources;
    set_pre(20'h00000);
    for (int s = 1; s < 3; s++)
    begin
      src = clk_src_e'(s); c = COUNT_OUT; pulse(1);
      chk(COUNT_OUT, c + 32'h1);
    end
    src = SRC_HSE; c = COUNT_OUT; pulse(127);
    chk(COUNT_OUT, c);
    pulse(1);
    chk(COUNT_OUT, c + 32'h1);
    chk(32'(TICK_IRQ_OUT), 32'h1);
    mask.tick = 1'b0; step(1);
    chk(32'(TICK_IRQ_OUT), 32'h0);
    chk(32'(FLAGS_OUT.tick), 32'h1);
    clr.tick = 1'b1; step(1); clr.tick = 1'b0; step(1);
    chk(32'(FLAGS_OUT.tick), 32'h0);
    // no source selected: every pin toggles, yet nothing may count
    src = SRC_NONE;
    c = COUNT_OUT;
    {lse, lsi, high_speed_external_clock} = 3'h7;
    step(8);
    {lse, lsi, high_speed_external_clock} = 3'h0;
    step(8);
    chk(COUNT_OUT, c);
    chk(32'(FLAGS_OUT.tick), 32'h0);
    src = SRC_LSI; set_pre(20'h00002); c = COUNT_OUT; pulse(2);
    chk(COUNT_OUT, c);
    pulse(1);
    chk(COUNT_OUT, c + 32'h1);
  endtask
  // alarm while in low-power states, then wrap past all ones
  task t_alarm;
    set_pre(20'h00000); stop = 1'b1; stby = 1'b1;
    cnt_val = 32'hFFFFFFFD; alm_val = 32'hFFFFFFFE; cnt_ld = 1'b1; alm_ld = 1'b1;
    step(1); cnt_ld = 1'b0; alm_ld = 1'b0; step(1);
    ev_n = 0; sb_n = 0; pulse(1);
    chk(32'(FLAGS_OUT.alarm), 32'h1);
    chk(32'(ALARM_IRQ_OUT), 32'h1);
    chk(ev_n, 32'h1);
    chk(sb_n, 32'h1);
    pulse(2);
    chk(COUNT_OUT, 32'h0);
    chk(ev_n, 32'h1);
    mask.alarm = 1'b0; step(1);
    chk(32'(ALARM_IRQ_OUT), 32'h0);
    clr.alarm = 1'b1; step(1); clr.alarm = 1'b0; step(1);
    chk(32'(FLAGS_OUT.alarm), 32'h0);
    // match outside Standby: event again, no exit pulse; masked irq stays low
    stby = 1'b0;
    cnt_val = 32'hFFFFFFFD;
    cnt_ld = 1'b1;
    step(1);
    cnt_ld = 1'b0;
    step(1);
    pulse(1);
    chk(32'(FLAGS_OUT.alarm), 32'h1);
    chk(32'(ALARM_IRQ_OUT), 32'h0);
    chk(ev_n, 32'h2);
    chk(sb_n, 32'h1);
    mask.alarm = 1'b1;
    step(1);
    chk(32'(ALARM_IRQ_OUT), 32'h1);
  endtask
  task t_cal;
    pulse(64); cal_t = 0; pulse(64);
    chk(cal_t, 32'h0);
    cal_en = 1'b1; step(2); cal_t = 0; pulse(128);
    chk(cal_t, 32'h4);
  endtask
  task bkp_wr(input logic [5:0] a, input logic [15:0] d);
    addr = a; wdata = d; we = 1'b1; step(1); we = 1'b0; step(1);
  endtask
  task bkp_rd(input logic [5:0] a, input logic [15:0] d);
    addr = a; step(2);
    chk(32'(BKP_RDATA_OUT), 32'(d));
  endtask
  // store survives both resets; index 42 lies outside the store
  task t_backup;
    bkp_wr(6'h00, 16'h1234); bkp_wr(6'h29, 16'hA5C3); bkp_wr(6'h2A, 16'hFFFF);
    bkp_rd(6'h00, 16'h1234); bkp_rd(6'h29, 16'hA5C3); bkp_rd(6'h2A, 16'h0000);
    rst_n = 1'b0; bkp_rst_n = 1'b0; step(2);
    chk(32'(BKP_RDATA_OUT), 32'h0);
    rst_n = 1'b1; bkp_rst_n = 1'b1; step(1);
    bkp_rd(6'h00, 16'h1234);
    bkp_rd(6'h29, 16'hA5C3);
  endtask
  task end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    // roughly three times the expected run of some 3,300 cycles
    #250000;
    err_count++;
    end_sim();
  end
  initial
  begin
    {rst_n, bkp_rst_n, lse, lsi, high_speed_external_clock, stop, stby, pre_ld, cnt_ld, alm_ld} = 10'h000;
    {cal_en, we, addr, wdata, pre_val, cnt_val, alm_val} = '0;
    src = SRC_LSE; clr = 2'h0; mask = 2'h3; cal_p = 1'b0;
    step(4);
    rst_n = 1'b1; bkp_rst_n = 1'b1; step(1);
    chk(COUNT_OUT, 32'h0);
    chk(32'(FLAGS_OUT), 32'h0);
    t_sources();
    t_alarm();
    t_cal();
    t_backup();
    end_sim();
  end
endmodule

// ===== hw/rtc_clk_sel.sv
// clock source selection and edge detection for the real-time clock
// assumes slow clocks arrive as pins far below the 40 MHz system clock
`timescale 1ns/10ps
`include "rtc_defs.svh"
module rtc_clk_sel
  import rtc_pkg::*;
(
  input  wire logic     clk_in,
  input  wire logic     reset_n_in,
  input  wire logic     lse_in,
  input  wire logic     lsi_in,
  input  wire logic     hse_in,
  input  wire clk_src_e src_in,
  output logic          src_tick_out
);
  logic [2:0] lse_q, lse_d, lsi_q, lsi_d, hse_q, hse_d;
  logic [2:0] agreed_q, agreed_d; // per pin {hse, lsi, lse}: level last agreed by stages two and three
  logic [`RTC_HSE_DIV_W-1:0] hdiv_q, hdiv_d;
  logic lse_rise, lsi_rise, hse_rise, hse_div_tick;

  // three-stage synchronisers; a level counts once stages two and three agree,
  // so a pin edge close to the clock edge cannot give two ticks
  always_comb
  begin
    lse_d = {lse_q[1:0], lse_in};
    lsi_d = {lsi_q[1:0], lsi_in};
    hse_d = {hse_q[1:0], hse_in};
    agreed_d[0] = (lse_q[1] == lse_q[2]) ? lse_q[2] : agreed_q[0];
    agreed_d[1] = (lsi_q[1] == lsi_q[2]) ? lsi_q[2] : agreed_q[1];
    agreed_d[2] = (hse_q[1] == hse_q[2]) ? hse_q[2] : agreed_q[2];
    lse_rise = lse_q[1] & lse_q[2] & ~agreed_q[0];
    lsi_rise = lsi_q[1] & lsi_q[2] & ~agreed_q[1];
    hse_rise = hse_q[1] & hse_q[2] & ~agreed_q[2];
    hse_div_tick = hse_rise && (hdiv_q == `RTC_HSE_DIV_W'(`RTC_HSE_DIV - 1));
    hdiv_d = hse_rise ? hdiv_q + `RTC_HSE_DIV_W'(1) : hdiv_q; // divide by 128
    case (src_in)
      SRC_LSE: src_tick_out = lse_rise;
      SRC_LSI: src_tick_out = lsi_rise;
      SRC_HSE: src_tick_out = hse_div_tick;
      default: src_tick_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      lse_q  <= 3'h0;
      lsi_q  <= 3'h0;
      hse_q  <= 3'h0;
      hdiv_q <= '0;
      agreed_q <= 3'h0; // idle pins are low, so no false edge after reset
    end
    else
    begin
      lse_q  <= lse_d;
      lsi_q  <= lsi_d;
      hse_q  <= hse_d;
      hdiv_q <= hdiv_d;
      agreed_q <= agreed_d;
    end
  end
endmodule

// ===== hw/rtc_defs.svh
// constants for the real-time clock with backup store
// assumes inclusion by the package and the design modules
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define RTC_CNT_W        32
`define RTC_PRE_W        20
`define RTC_PRE_RESET    20'h07FFF
`define RTC_HSE_DIV      128
`define RTC_HSE_DIV_W    7
`define RTC_CAL_DIV      64
`define RTC_CAL_DIV_W    6
`define RTC_BKP_NUM      42
`define RTC_BKP_W        16
`define RTC_BKP_IDX_W    6
`define RTC_SRC_LSE      2'h1
`define RTC_SRC_LSI      2'h2
`define RTC_SRC_HSE      2'h3
`endif

// ===== hw/rtc_pkg.sv
// types shared by the real-time clock files
// assumes rtc_defs.svh on the include path
`include "rtc_defs.svh"
package rtc_pkg;
  typedef enum logic [1:0]
  {
    SRC_NONE = 2'b00,
    SRC_LSE  = 2'b01,
    SRC_LSI  = 2'b10,
    SRC_HSE  = 2'b11
  } clk_src_e;
  typedef struct packed
  {
    logic alarm;
    logic tick;
  } rtc_flags_s;
endpackage

// ===== hw/rtc_top.sv
// real-time clock: prescaler, 32-bit counter, alarm, flags, backup store
// assumes one 40 MHz clock; slow clocks and low-power states arrive as pins
// Behaviour
// - 32-bit counter, alarm on compare match
// - 20-bit prescaler, reset gives one second
// - source: low-speed crystal, RC, fast/128
// - drives 512 Hz calibration output
// - alarm and periodic tick interrupts
// - forty-two 16-bit backup registers
// - backup contents survive every reset
// - keeps running in Stop and Standby
// - alarm routed to external event line
// - alarm causes exit from Standby
`timescale 1ns/10ps
`include "rtc_defs.svh"
module rtc_top
  import rtc_pkg::*;
#(
  parameter int CNT_W = `RTC_CNT_W,
  parameter int PRE_W = `RTC_PRE_W
)
(
  input  wire logic             CLK_IN,
  input  wire logic             RESET_N_IN,
  input  wire logic             BKP_RESET_N_IN,
  input  wire logic             LSE_CLK_IN,
  input  wire logic             LSI_CLK_IN,
  input  wire logic             HIGH_SPEED_EXTERNAL_CLOCK_IN,
  input  wire clk_src_e         CLK_SRC_IN,
  input  wire logic             STOP_IN,
  input  wire logic             STANDBY_IN,
  input  wire logic [PRE_W-1:0] PRE_RELOAD_IN,
  input  wire logic             PRE_LOAD_IN,
  input  wire logic [CNT_W-1:0] CNT_WDATA_IN,
  input  wire logic             CNT_LOAD_IN,
  input  wire logic [CNT_W-1:0] ALARM_WDATA_IN,
  input  wire logic             ALARM_LOAD_IN,
  input  wire rtc_flags_s       FLAG_CLR_IN,
  input  wire rtc_flags_s       IRQ_MASK_IN,
  input  wire logic             CAL_EN_IN,
  input  wire logic             BKP_WE_IN,
  input  wire logic [5:0]       BKP_ADDR_IN,
  input  wire logic [15:0]      BKP_WDATA_IN,
  output logic [CNT_W-1:0]      COUNT_OUT,
  output rtc_flags_s            FLAGS_OUT,
  output logic                  ALARM_IRQ_OUT,
  output logic                  TICK_IRQ_OUT,
  output logic                  CAL_OUT,
  output logic                  EXTERNAL_EVENT_LINE_OUT,
  output logic                  STANDBY_EXIT_OUT,
  output logic [15:0]           BKP_RDATA_OUT
);
  logic                      src_tick;
  logic [PRE_W-1:0]          pre_q, pre_d, reload_q, reload_d;
  logic [CNT_W-1:0]          cnt_q, cnt_d, alarm_q, alarm_d;
  rtc_flags_s                flags_q, flags_d;
  logic [`RTC_CAL_DIV_W-1:0] cal_q, cal_d;
  logic                      cal_out_q, cal_out_d, base_tick, match;
  logic                      evt_q, evt_d, sbx_q, sbx_d;
  logic [`RTC_BKP_W-1:0]     bkp_q [`RTC_BKP_NUM];
  logic [`RTC_BKP_W-1:0]     rdata_q;

  rtc_clk_sel u_sel
  (
    .clk_in       (CLK_IN),
    .reset_n_in   (RESET_N_IN),
    .lse_in       (LSE_CLK_IN),
    .lsi_in       (LSI_CLK_IN),
    .hse_in       (HIGH_SPEED_EXTERNAL_CLOCK_IN),
    .src_in       (CLK_SRC_IN),
    .src_tick_out (src_tick)
  );

  // time base, counter, alarm and flags; low-power pins never gate this
  always_comb
  begin
    base_tick = src_tick && (pre_q == '0);
    reload_d  = PRE_LOAD_IN ? PRE_RELOAD_IN : reload_q;
    pre_d     = pre_q;
    if (PRE_LOAD_IN)
      pre_d = PRE_RELOAD_IN;
    else if (src_tick)
      pre_d = (pre_q == '0) ? reload_q : pre_q - PRE_W'(1);
    cnt_d = cnt_q;
    if (CNT_LOAD_IN)
      cnt_d = CNT_WDATA_IN;
    else if (base_tick)
      cnt_d = cnt_q + CNT_W'(1);
    alarm_d = ALARM_LOAD_IN ? ALARM_WDATA_IN : alarm_q;
    match   = base_tick && !CNT_LOAD_IN && (cnt_d == alarm_q);
    // set wins over a clear in the same cycle
    flags_d.alarm = match | (flags_q.alarm & ~FLAG_CLR_IN.alarm);
    flags_d.tick  = base_tick | (flags_q.tick & ~FLAG_CLR_IN.tick);
    evt_d = match;
    sbx_d = match && STANDBY_IN;
    // 512 Hz from a 32.768 kHz source: toggle every 32 source ticks
    cal_d     = cal_q;
    cal_out_d = cal_out_q;
    if (!CAL_EN_IN)
    begin
      cal_d     = '0;
      cal_out_d = 1'b0;
    end
    else if (src_tick)
    begin
      cal_d = cal_q + `RTC_CAL_DIV_W'(2);
      if (cal_q == `RTC_CAL_DIV_W'(`RTC_CAL_DIV - 2))
        cal_out_d = ~cal_out_q;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      pre_q     <= `RTC_PRE_RESET;
      reload_q  <= `RTC_PRE_RESET;
      cnt_q     <= '0;
      alarm_q   <= '1;
      flags_q   <= '0;
      cal_q     <= '0;
      cal_out_q <= 1'b0;
      evt_q     <= 1'b0;
      sbx_q     <= 1'b0;
    end
    else
    begin
      pre_q     <= pre_d;
      reload_q  <= reload_d;
      cnt_q     <= cnt_d;
      alarm_q   <= alarm_d;
      flags_q   <= flags_d;
      cal_q     <= cal_d;
      cal_out_q <= cal_out_d;
      evt_q     <= evt_d;
      sbx_q     <= sbx_d;
    end
  end

  // interrupts gated per source by mask
  assign ALARM_IRQ_OUT           = flags_q.alarm & IRQ_MASK_IN.alarm;
  assign TICK_IRQ_OUT            = flags_q.tick & IRQ_MASK_IN.tick;
  assign COUNT_OUT               = cnt_q;
  assign FLAGS_OUT               = flags_q;
  assign CAL_OUT                 = cal_out_q;
  assign EXTERNAL_EVENT_LINE_OUT = evt_q;
  assign STANDBY_EXIT_OUT        = sbx_q;
  assign BKP_RDATA_OUT           = rdata_q;

  // backup store: no reset at all, so no system reset can clear it
  genvar gi;
  generate
    for (gi = 0; gi < `RTC_BKP_NUM; gi++)
    begin : g_bkp
      always_ff @(posedge CLK_IN)
      begin
        if (BKP_WE_IN && BKP_ADDR_IN == 6'(gi))
          bkp_q[gi] <= BKP_WDATA_IN;
      end
    end
  endgenerate

  // registered read; unmapped index reads zero; backup-domain reset only
  always_ff @(posedge CLK_IN or negedge BKP_RESET_N_IN)
  begin
    if (!BKP_RESET_N_IN)
      rdata_q <= '0;
    else
      rdata_q <= (BKP_ADDR_IN < 6'(`RTC_BKP_NUM)) ? bkp_q[BKP_ADDR_IN] : '0;
  end

  // checks on flags, events and the counting path
  a_alarm_irq: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    match && IRQ_MASK_IN.alarm |=> ALARM_IRQ_OUT || !IRQ_MASK_IN.alarm)
    else $error("alarm irq not raised");
  a_alarm_event: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    match |=> EXTERNAL_EVENT_LINE_OUT && flags_q.alarm)
    else $error("alarm event missing");
  a_count_step: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    base_tick && !CNT_LOAD_IN |=> COUNT_OUT == $past(cnt_q) + CNT_W'(1))
    else $error("counter did not step");
  a_count_hold: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !base_tick && !CNT_LOAD_IN |=> $stable(COUNT_OUT))
    else $error("counter moved without tick");
  a_tick_flag: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    base_tick |=> flags_q.tick)
    else $error("tick flag not set");
  a_flag_sticky: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    flags_q.tick && !FLAG_CLR_IN.tick |=> flags_q.tick)
    else $error("tick flag dropped");
  a_standby_exit: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    match && STANDBY_IN |=> STANDBY_EXIT_OUT)
    else $error("standby exit missing");
  a_pre_reload: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    src_tick && pre_q == '0 && !PRE_LOAD_IN |=> pre_q == $past(reload_q))
    else $error("prescaler reload wrong");

  // loads, clears and the prescaler step
  a_pre_count: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    src_tick && pre_q != '0 && !PRE_LOAD_IN |=> pre_q == $past(pre_q) - PRE_W'(1))
    else $error("prescaler did not step");
  a_load_wins: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    CNT_LOAD_IN |=> COUNT_OUT == $past(CNT_WDATA_IN) && !EXTERNAL_EVENT_LINE_OUT)
    else $error("counter load lost");
  a_alarm_clear: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    FLAG_CLR_IN.alarm && !match |=> !flags_q.alarm)
    else $error("alarm flag not cleared");
  a_tick_clear: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    FLAG_CLR_IN.tick && !base_tick |=> !flags_q.tick)
    else $error("tick flag not cleared");

  // low-power pins, wake outputs and calibration
  a_lowpower_run: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (STOP_IN || STANDBY_IN) && base_tick && !CNT_LOAD_IN |=> COUNT_OUT == $past(cnt_q) + CNT_W'(1))
    else $error("counter halted in low power");
  a_exit_qualified: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !STANDBY_IN |=> !STANDBY_EXIT_OUT)
    else $error("standby exit outside standby");
  a_event_pulse: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    EXTERNAL_EVENT_LINE_OUT |=> !EXTERNAL_EVENT_LINE_OUT)
    else $error("event line longer than a pulse");
  a_cal_idle: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !CAL_EN_IN |=> !CAL_OUT)
    else $error("calibration output while disabled");
endmodule
